// [core/ioc_top.sv]
/*
 * Internal oscillator control: high-frequency control register, fixed
 * multiplier register, low-frequency oscillator control and timer capture.
 * Assumes a synchronous byte-wide register port on i_clk; i_vbus is a pin.
 */
// Operation
// - HF enable stops or runs oscillator, resets 1
// - HF ready reads 1 only when running
// - Suspend write halts oscillator; wake restarts it
// - Bits 4:2 read zero, writes ignored
// - System clock: fixed divide-by-4 then divider
// - HF divider codes 00..11 give /8../1
// - Multiplier register shows present, enabled, working
// - Multiplier enable, init, ready always read 1
// - Multiplier input select always reads 00
// - LF oscillator 80 kHz with /1,2,4,8
// - Four-bit trim adjusts LF frequency
// - Timer 2 falling, timer 3 rising capture
// - Capture copies timer count into reload
// - LF divider codes 00..11 give /8../1
// - LF ready clears only on reset, divider change
// - Suspended clock waits for USB or VBUS edge
`timescale 1ns/1ps
`include "ioc_defs.svh"
module ioc_top
	import ioc_pkg::*;
#(
	parameter int LF_HALF_CYC = (`IOC_CLK_MHZ * 1000) / (2 * `IOC_LF_NOM_KHZ)
)
(
	// Clock and reset.
	input wire logic i_clk,
	input wire logic i_rstn,
	// Register port.
	input wire logic [7:0] i_sfr_addr,
	input wire logic i_sfr_wr,
	input wire logic i_sfr_rd,
	input wire logic [7:0] i_sfr_wdata,
	output logic [7:0] o_sfr_rdata,
	// Wake sources.
	input wire logic i_usb_wake,
	input wire logic i_vbus,
	// Timer capture hookup.
	input wire logic i_t2_lf_capture,
	input wire logic i_t3_lf_capture,
	input wire logic [15:0] i_t2_count,
	input wire logic [15:0] i_t3_count,
	output logic [15:0] o_t2_reload,
	output logic [15:0] o_t3_reload,
	output logic o_t2_capture,
	output logic o_t3_capture,
	// Clocks and status.
	output logic o_sys_clk_en,
	output logic o_hf_running,
	output logic o_suspended,
	output logic o_lf_clk
);
	localparam int HF_SETTLE_CYC = (`IOC_HF_SETTLE_NS * `IOC_CLK_MHZ + 999) / 1000;
	localparam int LF_HALF_MIN = LF_HALF_CYC - 8 * `IOC_LF_TRIM_STEP;

	logic hf_on_reg;
	logic hf_ok_reg;
	ioc_div_code_t hf_div_reg;
	logic [7:0] hf_settle_reg;
	logic lf_on_reg;
	logic lf_ok_reg;
	logic [3:0] lf_trim_reg;
	ioc_div_code_t lf_div_reg;
	logic [12:0] lf_cnt_reg;
	logic [3:0] lf_settle_reg;
	logic vbus_s1_reg, vbus_s2_reg, vbus_s3_reg;
	logic hf_wr, lf_wr, lf_div_change, wake, lf_tick;
	logic [12:0] lf_half;

	ioc_div_if hf_bus ();
	ioc_div_if lf_bus ();

	assign hf_wr = i_sfr_wr && (i_sfr_addr == `IOC_HF_ADDR);
	assign lf_wr = i_sfr_wr && (i_sfr_addr == `IOC_LF_ADDR);
	assign lf_div_change = lf_wr && (i_sfr_wdata[1:0] != lf_div_reg);

	// ----------------------------------------------------------------------
	// Register port
	// ----------------------------------------------------------------------
	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			hf_on_reg <= 1'(`IOC_HF_RESET >> `IOC_ON_BIT);
			hf_div_reg <= IOC_DIV8;
		end else if (hf_wr) begin
			hf_on_reg <= i_sfr_wdata[`IOC_ON_BIT];
			hf_div_reg <= ioc_div_code_t'(i_sfr_wdata[1:0]);
		end
	end

	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			lf_on_reg <= 1'b0;
			lf_trim_reg <= `IOC_LF_TRIM_RESET;
			lf_div_reg <= IOC_DIV8;
		end else if (lf_wr) begin
			lf_on_reg <= i_sfr_wdata[`IOC_ON_BIT];
			lf_trim_reg <= i_sfr_wdata[5:2];
			lf_div_reg <= ioc_div_code_t'(i_sfr_wdata[1:0]);
		end
	end

	// Reads are registered; unmapped addresses read zero.
	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			o_sfr_rdata <= 8'h00;
		end else if (i_sfr_rd) begin
			case (i_sfr_addr)
				`IOC_HF_ADDR: o_sfr_rdata <= {hf_on_reg, hf_ok_reg, o_suspended, 3'h0, hf_div_reg};
				`IOC_MUL_ADDR: o_sfr_rdata <= `IOC_MUL_VALUE;
				`IOC_LF_ADDR: o_sfr_rdata <= {lf_on_reg, lf_ok_reg, lf_trim_reg, lf_div_reg};
				default: o_sfr_rdata <= 8'h00;
			endcase
		end
	end

	// ----------------------------------------------------------------------
	// Suspend and wake
	// ----------------------------------------------------------------------
	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			vbus_s1_reg <= 1'b0;
			vbus_s2_reg <= 1'b0;
			vbus_s3_reg <= 1'b0;
		end else begin
			vbus_s1_reg <= i_vbus;
			vbus_s2_reg <= vbus_s1_reg;
			vbus_s3_reg <= vbus_s2_reg;
		end
	end

	assign wake = i_usb_wake || (vbus_s2_reg != vbus_s3_reg);

	// A wake in the same cycle as the suspend write wins, so no wake is lost.
	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			o_suspended <= 1'b0;
		end else if (wake) begin
			o_suspended <= 1'b0;
		end else if (hf_wr && i_sfr_wdata[`IOC_SUSP_BIT]) begin
			o_suspended <= 1'b1;
		end
	end

	// ----------------------------------------------------------------------
	// High-frequency side
	// ----------------------------------------------------------------------
	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			o_hf_running <= 1'b1;
		end else begin
			o_hf_running <= hf_on_reg && !o_suspended;
		end
	end

	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			hf_settle_reg <= 8'(HF_SETTLE_CYC);
			hf_ok_reg <= 1'b1;
		end else if (!o_hf_running) begin
			hf_settle_reg <= 8'h00;
			hf_ok_reg <= 1'b0;
		end else if (hf_settle_reg != 8'(HF_SETTLE_CYC)) begin
			hf_settle_reg <= hf_settle_reg + 8'h01;
			hf_ok_reg <= 1'b0;
		end else begin
			hf_ok_reg <= 1'b1;
		end
	end

	// Total ratio is 4 times 8, 4, 2 or 1 clock cycles.
	assign hf_bus.run = o_hf_running;
	assign hf_bus.tick = 1'b1;
	assign hf_bus.shift = 3'h5 - {1'b0, hf_div_reg};

	ioc_div u_hf_div (
		.i_clk(i_clk),
		.i_rstn(i_rstn),
		.bus(hf_bus.div)
	);

	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			o_sys_clk_en <= 1'b0;
		end else begin
			o_sys_clk_en <= hf_bus.pulse;
		end
	end

	// ----------------------------------------------------------------------
	// Low-frequency side
	// ----------------------------------------------------------------------
	// Trim 0 gives the shortest half period, 15 the longest.
	assign lf_half = 13'(LF_HALF_MIN) + 13'(lf_trim_reg * `IOC_LF_TRIM_STEP);
	assign lf_tick = lf_on_reg && (lf_cnt_reg == lf_half - 13'h0001);

	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			lf_cnt_reg <= 13'h0000;
		end else if (!lf_on_reg || lf_tick) begin
			lf_cnt_reg <= 13'h0000;
		end else begin
			lf_cnt_reg <= lf_cnt_reg + 13'h0001;
		end
	end

	assign lf_bus.run = lf_on_reg;
	assign lf_bus.tick = lf_tick;
	assign lf_bus.shift = 3'h3 - {1'b0, lf_div_reg};

	ioc_div u_lf_div (
		.i_clk(i_clk),
		.i_rstn(i_rstn),
		.bus(lf_bus.div)
	);

	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			o_lf_clk <= 1'b0;
		end else if (lf_bus.pulse) begin
			o_lf_clk <= !o_lf_clk;
		end
	end

	// Disabling the oscillator leaves the ready flag alone; only a divider change clears it.
	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			lf_settle_reg <= 4'h0;
			lf_ok_reg <= 1'b0;
		// The flag is set only while still settling, so later pulses never mask a divider change.
		end else if (lf_bus.pulse && !lf_ok_reg &&
				lf_settle_reg == 4'(`IOC_LF_SETTLE_EDGES - 1)) begin
			lf_settle_reg <= lf_settle_reg;
			lf_ok_reg <= 1'b1;
		end else if (lf_div_change) begin
			lf_settle_reg <= 4'h0;
			lf_ok_reg <= 1'b0;
		end else if (lf_bus.pulse && !lf_ok_reg) begin
			lf_settle_reg <= lf_settle_reg + 4'h1;
		end
	end

	// ----------------------------------------------------------------------
	// Timer capture
	// ----------------------------------------------------------------------
	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			o_t2_capture <= 1'b0;
			o_t2_reload <= 16'h0000;
		end else begin
			o_t2_capture <= lf_bus.pulse && o_lf_clk && i_t2_lf_capture;
			if (lf_bus.pulse && o_lf_clk && i_t2_lf_capture) begin
				o_t2_reload <= i_t2_count;
			end
		end
	end

	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			o_t3_capture <= 1'b0;
			o_t3_reload <= 16'h0000;
		end else begin
			o_t3_capture <= lf_bus.pulse && !o_lf_clk && i_t3_lf_capture;
			if (lf_bus.pulse && !o_lf_clk && i_t3_lf_capture) begin
				o_t3_reload <= i_t3_count;
			end
		end
	end

	// ----------------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------------
	a_hf_stop_clock: assert property (@(posedge i_clk) disable iff (!i_rstn)
		!o_hf_running |=> ##1 !o_sys_clk_en) else $error("system clock ran while stopped");
	a_hf_ready_off: assert property (@(posedge i_clk) disable iff (!i_rstn)
		!o_hf_running |=> !hf_ok_reg) else $error("HF ready while stopped");
	a_susp_wake: assert property (@(posedge i_clk) disable iff (!i_rstn)
		o_suspended && i_usb_wake |=> !o_suspended ##1 o_hf_running == $past(hf_on_reg))
		else $error("wake did not end suspend");
	a_hf_unused_zero: assert property (@(posedge i_clk) disable iff (!i_rstn)
		i_sfr_rd && i_sfr_addr == `IOC_HF_ADDR |=> o_sfr_rdata[4:2] == 3'h0)
		else $error("unused HF bits not zero");
	a_sys_min_gap: assert property (@(posedge i_clk) disable iff (!i_rstn)
		o_sys_clk_en |=> !o_sys_clk_en [*3]) else $error("system clock faster than /4");
	a_mul_fixed: assert property (@(posedge i_clk) disable iff (!i_rstn)
		i_sfr_rd && i_sfr_addr == `IOC_MUL_ADDR |=> o_sfr_rdata == `IOC_MUL_VALUE)
		else $error("multiplier register not fixed");
	a_lf_ready_hold: assert property (@(posedge i_clk) disable iff (!i_rstn)
		lf_ok_reg && !lf_div_change |=> lf_ok_reg) else $error("LF ready dropped");
	a_t2_fall_edge: assert property (@(posedge i_clk) disable iff (!i_rstn)
		o_t2_capture |-> $past(o_lf_clk) && !o_lf_clk) else $error("T2 not on falling edge");
	a_t3_copy_count: assert property (@(posedge i_clk) disable iff (!i_rstn)
		o_t3_capture |-> o_t3_reload == $past(i_t3_count) && o_lf_clk)
		else $error("T3 reload mismatch");
endmodule : ioc_top

// [core/ioc_defs.svh]
/*
 * Register addresses, field positions, reset values and timing figures for
 * the internal oscillator control block.
 * Assumes it is included by bare name once per compilation unit.
 */
`ifndef IOC_DEFS_SVH
`define IOC_DEFS_SVH

// ----------------------------------------------------------------------
// Register addresses
// ----------------------------------------------------------------------
`define IOC_HF_ADDR 8'hB2
`define IOC_MUL_ADDR 8'hB9
`define IOC_LF_ADDR 8'h86

// ----------------------------------------------------------------------
// Field positions and reset values
// ----------------------------------------------------------------------
`define IOC_ON_BIT 7
`define IOC_OK_BIT 6
`define IOC_SUSP_BIT 5
`define IOC_HF_RESET 8'hC0
`define IOC_MUL_VALUE 8'hE0
`define IOC_LF_TRIM_RESET 4'h8

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define IOC_CLK_MHZ 250
`define IOC_HF_SETTLE_NS 200
`define IOC_LF_NOM_KHZ 80
`define IOC_LF_TRIM_STEP 16
`define IOC_LF_SETTLE_EDGES 4

`endif

// [core/ioc_pkg.sv]
/*
 * Types shared by the internal oscillator control modules.
 * Assumes nothing of its surroundings.
 */
package ioc_pkg;
	typedef logic [7:0] ioc_byte_t;
	typedef enum logic [1:0] {
		IOC_DIV8 = 2'h0,
		IOC_DIV4 = 2'h1,
		IOC_DIV2 = 2'h2,
		IOC_DIV1 = 2'h3
	} ioc_div_code_t;
endpackage : ioc_pkg

// [core/ioc_div_if.sv]
/*
 * Carrier between the oscillator controller and a clock-enable divider.
 * Assumes both ends share one clock.
 */
`timescale 1ns/1ps
interface ioc_div_if;
	logic run;
	logic tick;
	logic [2:0] shift;
	logic pulse;
	modport ctl (output run, output tick, output shift, input pulse);
	modport div (input run, input tick, input shift, output pulse);
endinterface : ioc_div_if

// [core/ioc_div.sv]
/*
 * Clock-enable divider: one pulse per 2**shift input ticks.
 * Assumes tick and shift come from logic on the same clock.
 */
`timescale 1ns/1ps
module ioc_div
	import ioc_pkg::*;
(
	// Clock and reset.
	input wire logic i_clk,
	input wire logic i_rstn,
	// Control side.
	ioc_div_if.div bus
);
	logic [7:0] cnt_reg;
	logic [2:0] cur_reg;
	logic pulse_reg;
	logic wrap;

	assign wrap = (cnt_reg == 8'((9'h001 << cur_reg) - 9'h001));
	assign bus.pulse = pulse_reg;

	// ----------------------------------------------------------------------
	// Counting
	// ----------------------------------------------------------------------
	// A new ratio is taken only at a period boundary, so no runt pulse appears.
	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			cnt_reg <= 8'h00;
			cur_reg <= 3'h0;
			pulse_reg <= 1'b0;
		end else if (!bus.run) begin
			cnt_reg <= 8'h00;
			cur_reg <= bus.shift;
			pulse_reg <= 1'b0;
		end else if (bus.tick) begin
			pulse_reg <= wrap;
			if (wrap) begin
				cnt_reg <= 8'h00;
				cur_reg <= bus.shift;
			end else begin
				cnt_reg <= cnt_reg + 8'h01;
			end
		end else begin
			pulse_reg <= 1'b0;
		end
	end
endmodule : ioc_div

// [test/ioc_bench.sv]
/*
 * Self-checking bench for the internal oscillator control block.
 * Assumes ioc_pkg, ioc_div_if, ioc_div and ioc_top are compiled before it.
 */
`timescale 1ns/1ps
`define CHK(nm, e, g) begin check_count++; if ((g) !== (e)) begin err_total++; \
	$display("unexpected %s: expected %h seen %h", nm, e, g); end end
module ioc_bench
	import ioc_pkg::*;
;
	logic i_clk = 1'b0;
	logic i_rstn = 1'b0;
	logic [7:0] i_sfr_addr = 8'h00;
	logic [7:0] i_sfr_wdata = 8'h00;
	logic i_sfr_wr = 1'b0;
	logic i_sfr_rd = 1'b0;
	logic i_usb_wake = 1'b0;
	logic i_vbus = 1'b0;
	logic i_t2_lf_capture = 1'b0;
	logic i_t3_lf_capture = 1'b0;
	logic [15:0] i_t2_count = 16'h1234;
	logic [15:0] i_t3_count = 16'hABCD;
	logic [7:0] o_sfr_rdata;
	logic [15:0] o_t2_reload;
	logic [15:0] o_t3_reload;
	logic o_t2_capture, o_t3_capture, o_sys_clk_en, o_hf_running, o_suspended, o_lf_clk;
	int err_total = 0;
	int check_count = 0;
	int n;

	always #2 i_clk = ~i_clk;

	// A short low-frequency half period keeps the run brief; base tick is 200-128+16*trim.
	ioc_top #(.LF_HALF_CYC(200)) i_ioc_top (
		.i_clk(i_clk), .i_rstn(i_rstn),
		.i_sfr_addr(i_sfr_addr), .i_sfr_wr(i_sfr_wr), .i_sfr_rd(i_sfr_rd),
		.i_sfr_wdata(i_sfr_wdata), .o_sfr_rdata(o_sfr_rdata),
		.i_usb_wake(i_usb_wake), .i_vbus(i_vbus),
		.i_t2_lf_capture(i_t2_lf_capture), .i_t3_lf_capture(i_t3_lf_capture),
		.i_t2_count(i_t2_count), .i_t3_count(i_t3_count),
		.o_t2_reload(o_t2_reload), .o_t3_reload(o_t3_reload),
		.o_t2_capture(o_t2_capture), .o_t3_capture(o_t3_capture),
		.o_sys_clk_en(o_sys_clk_en), .o_hf_running(o_hf_running),
		.o_suspended(o_suspended), .o_lf_clk(o_lf_clk)
	);

	// ------------------------------------------------------------------
	// Register access
	// ------------------------------------------------------------------
	task automatic wr(input ioc_byte_t a, input ioc_byte_t d);
		@(negedge i_clk);
		i_sfr_addr = a;
		i_sfr_wdata = d;
		i_sfr_wr = 1'b1;
		@(negedge i_clk);
		i_sfr_wr = 1'b0;
	endtask : wr

	task automatic rd(input ioc_byte_t a, input ioc_byte_t e);
		@(negedge i_clk);
		i_sfr_addr = a;
		i_sfr_rd = 1'b1;
		@(negedge i_clk);
		i_sfr_rd = 1'b0;
		@(negedge i_clk);
		`CHK("read data", e, o_sfr_rdata)
	endtask : rd

	// ------------------------------------------------------------------
	// Measurement
	// ------------------------------------------------------------------
	// Cycles between two enable pulses; call twice after a change, since
	// the first period may still run at the old rate.
	task automatic sys_period(output int c);
		c = 0;
		for (int k = 0; k < 200 && o_sys_clk_en !== 1'b1; k++) @(negedge i_clk);
		do begin
			@(negedge i_clk);
			c++;
		end while (o_sys_clk_en !== 1'b1 && c < 200);
	endtask : sys_period

	task automatic lf_half(output int c);
		logic v;
		c = 0;
		v = o_lf_clk;
		for (int k = 0; k < 2000 && o_lf_clk === v; k++) @(negedge i_clk);
		v = o_lf_clk;
		do begin
			@(negedge i_clk);
			c++;
		end while (o_lf_clk === v && c < 2000);
	endtask : lf_half

	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", check_count, err_total);
		if (err_total == 0 && check_count > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask : report_and_stop

	initial begin
		#100000;
		err_total++;
		report_and_stop();
	end

	// ------------------------------------------------------------------
	// Tests
	// ------------------------------------------------------------------
	initial begin
		repeat (20) @(negedge i_clk);
		i_rstn = 1'b1;
		rd(8'hB2, 8'hC0);
		rd(8'hB9, 8'hE0);
		rd(8'h86, 8'h20);
		rd(8'h00, 8'h00);
		wr(8'hB9, 8'h1F);
		rd(8'hB9, 8'hE0);
		wr(8'hB2, 8'h1F);
		repeat (4) @(negedge i_clk);
		`CHK("hf running", 1'b0, o_hf_running)
		rd(8'hB2, 8'h03);
		wr(8'hB2, 8'h83);
		repeat (60) @(negedge i_clk);
		rd(8'hB2, 8'hC3);
		for (int c = 0; c < 4; c++) begin
			wr(8'hB2, 8'h80 + c[7:0]);
			sys_period(n);
			sys_period(n);
			`CHK("sys period", 32 >> c, n)
		end
		wr(8'hB2, 8'hA3);
		repeat (4) @(negedge i_clk);
		`CHK("suspended", 1'b1, o_suspended)
		`CHK("hf running", 1'b0, o_hf_running)
		n = 0;
		repeat (40) begin
			@(negedge i_clk);
			n += int'(o_sys_clk_en === 1'b1);
		end
		`CHK("pulses while halted", 0, n)
		i_usb_wake = 1'b1;
		@(negedge i_clk);
		i_usb_wake = 1'b0;
		repeat (3) @(negedge i_clk);
		`CHK("usb wake", 1'b0, o_suspended)
		`CHK("hf running", 1'b1, o_hf_running)
		wr(8'hB2, 8'hA3);
		repeat (4) @(negedge i_clk);
		`CHK("suspended", 1'b1, o_suspended)
		i_vbus = 1'b1;
		repeat (8) @(negedge i_clk);
		`CHK("vbus wake", 1'b0, o_suspended)

		// Low-frequency oscillator: trim 0, divide by 1, then trim 2, divide by 2.
		wr(8'h86, 8'h83);
		lf_half(n);
		lf_half(n);
		`CHK("lf half period", 72, n)
		repeat (400) @(negedge i_clk);
		rd(8'h86, 8'hC3);
		wr(8'h86, 8'hCA);
		rd(8'h86, 8'h8A);
		i_t2_lf_capture = 1'b1;
		i_t3_lf_capture = 1'b1;
		lf_half(n);
		lf_half(n);
		`CHK("lf half period", 208, n)
		for (int k = 0; k < 600 && o_t2_capture !== 1'b1; k++) @(negedge i_clk);
		`CHK("t2 capture", 1'b1, o_t2_capture)
		`CHK("t2 edge", 1'b0, o_lf_clk)
		`CHK("t2 reload", 16'h1234, o_t2_reload)
		@(negedge i_clk);
		`CHK("t2 capture pulse", 1'b0, o_t2_capture)
		for (int k = 0; k < 600 && o_t3_capture !== 1'b1; k++) @(negedge i_clk);
		`CHK("t3 capture", 1'b1, o_t3_capture)
		`CHK("t3 edge", 1'b1, o_lf_clk)
		`CHK("t3 reload", 16'hABCD, o_t3_reload)
		@(negedge i_clk);
		`CHK("t3 capture pulse", 1'b0, o_t3_capture)
		repeat (1000) @(negedge i_clk);
		rd(8'h86, 8'hCA);
		wr(8'h86, 8'h8E);
		rd(8'h86, 8'hCE);
		report_and_stop();
	end
endmodule : ioc_bench
